// ### rtl/scrx_map.vh
`ifndef SCRX_MAP_VH
`define SCRX_MAP_VH
// =====================================================================
// Register byte offsets.
`define SCRX_OFF_CTRL 12'h000
`define SCRX_OFF_DIV 12'h004
`define SCRX_OFF_STATUS 12'h008
`define SCRX_OFF_MASK 12'h00C
`define SCRX_OFF_DATA 12'h010
`define SCRX_OFF_LEVEL 12'h014
// =====================================================================
// Control register fields.
`define SCRX_CTRL_RX_EN 0
`define SCRX_CTRL_LOOP 1
`define SCRX_CTRL_ECHO 2
`define SCRX_CTRL_PLL_EN 3
`define SCRX_CTRL_PLL_FM 4
`define SCRX_CTRL_RX_NRZI 5
`define SCRX_CTRL_HUNT 6
`define SCRX_CTRL_SRST 7
`define SCRX_CTRL_RESET 8'h00
// =====================================================================
// Status and mask bits.
`define SCRX_ST_AVAIL 0
`define SCRX_ST_OVERRUN 1
`define SCRX_ST_FRAMING 2
`define SCRX_ST_ZERO 3
// =====================================================================
// Sampling constants.
`define SCRX_OVERSAMPLE 16
`define SCRX_SAMPLE_POINT 8
`define SCRX_FIFO_DEPTH 3
`define SCRX_DIV_RESET 16'h0000
`endif

// ### rtl/scrx_channel.v
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "scrx_map.vh"
// Function
// RULE_01: In 16x async mode sample each bit on count eight of sixteen.
// RULE_02: Three byte receive FIFO always on; character past full shift register overruns.
// RULE_03: Reading empty FIFO returns the last held character again.
// RULE_04: While locked by error, keep assembling characters until overrun.
// RULE_05: Hunt mode keeps FIFO contents until read or channel reset.
// RULE_06: With loopback and echo both on, echo wins the pin connection.
// RULE_07: During echo the transmitter never reaches the transmit pin.
// RULE_08: Recovered clock identical for NRZ and NRZI receive coding.
// RULE_09: Without the loop, the far end supplies a correctly phased clock.
// RULE_10: Loop tracks rate deviation up to one thirty-second.
// RULE_11: Loop samples at sixteen or thirty-two times bit rate per coding.
// RULE_12: Manchester decodes with loop in FM and receiver set to NRZ.
// RULE_13: Baud divider loads time constant only after software reset or zero.
// RULE_14: NRZ works with loop set NRZI and receiver set NRZ.
// RULE_15: FM loop limit is one sixteenth of peripheral clock.
// RULE_16: NRZ/NRZI loop limit is one thirty-second of peripheral clock.
// RULE_17: Peripheral clock runs all logic, resets and the baud divider.
// RULE_18: Overrun sets readable status flag that can raise an interrupt.
module scrx_channel #(
  parameter DIV_W = 16
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial pins.
  input wire rxd,
  input wire tx_data,
  output reg txd,
  // Interrupt.
  output reg irq
);

  // =====================================================================
  // Registers.
  reg [7:0] ctrl_reg;
  reg [DIV_W-1:0] tc_reg;
  reg [DIV_W-1:0] div_cnt_reg;
  reg [3:0] status_reg;
  reg [3:0] mask_reg;
  reg [7:0] fifo_mem [0:`SCRX_FIFO_DEPTH-1];
  reg [1:0] rd_ptr_reg;
  reg [1:0] wr_ptr_reg;
  reg [1:0] level_reg;
  reg [7:0] last_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [4:0] phase_reg;
  reg busy_reg;
  reg rx_prev_reg;
  reg pend_reg;
  reg [7:0] pend_data_reg;
  reg nrzi_prev_reg;
  reg fm_first_reg;

  wire wr_en = psel & penable & pwrite & pready;
  wire rd_en = psel & penable & ~pwrite & pready;
  wire srst = wr_en && paddr == `SCRX_OFF_CTRL && pwdata[`SCRX_CTRL_SRST];
  wire pll_en = ctrl_reg[`SCRX_CTRL_PLL_EN];
  wire pll_fm = ctrl_reg[`SCRX_CTRL_PLL_FM];
  wire echo = ctrl_reg[`SCRX_CTRL_ECHO];
  wire loop = ctrl_reg[`SCRX_CTRL_LOOP];

  // =====================================================================
  // Baud divider: one tick per sample clock.
  wire div_zero = div_cnt_reg == {DIV_W{1'b0}};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= `SCRX_DIV_RESET;
    end else if (srst || div_zero) begin
      div_cnt_reg <= tc_reg; // [RULE_13] [RULE_17]
    end else begin
      div_cnt_reg <= div_cnt_reg - 1'b1;
    end
  end
  wire tick = div_zero;

  // =====================================================================
  // Serial input select; echo has priority over loopback.
  wire rx_in = echo ? rxd : (loop ? tx_data : rxd); // [RULE_06]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
    end else if (echo) begin
      txd <= rxd; // [RULE_06] [RULE_07]
    end else if (loop) begin
      txd <= 1'b1;
    end else begin
      txd <= tx_data;
    end
  end

  // =====================================================================
  // Bit cell timing. Loop mode uses 16 ticks per cell for FM and 32 for
  // NRZ/NRZI, and re-centres on each line edge except one at the sample point; async uses 16x.
  wire [4:0] cell_len = (pll_en && !pll_fm) ? 5'd31 : 5'd15; // [RULE_11] [RULE_15] [RULE_16]
  wire [4:0] mid = (pll_en && !pll_fm) ? 5'd16 : 5'd8; // [RULE_01]
  wire edge_seen = rx_in != rx_prev_reg;
  wire sample = tick && busy_reg && phase_reg == mid - 5'd1;
  // Data decode: the loop clock is the same for NRZ and NRZI; only the
  // receiver coding changes the data. FM mode decodes Manchester by level.
  wire dec_bit = ctrl_reg[`SCRX_CTRL_RX_NRZI] ? ~(rx_in ^ nrzi_prev_reg) : rx_in; // [RULE_08] [RULE_14] [RULE_12]
  wire fifo_full = level_reg == 2'd3;
  wire char_done = sample && bit_cnt_reg == 4'd8;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 5'd0;
      busy_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      nrzi_prev_reg <= 1'b1;
      fm_first_reg <= 1'b0;
    end else if (srst || !ctrl_reg[`SCRX_CTRL_RX_EN]) begin
      busy_reg <= 1'b0;
      bit_cnt_reg <= 4'd0;
      phase_reg <= 5'd0;
      rx_prev_reg <= rx_in;
    end else if (tick) begin
      rx_prev_reg <= rx_in;
      fm_first_reg <= 1'b0;
      if (!busy_reg) begin
        if (!rx_in) begin
          busy_reg <= 1'b1;
          phase_reg <= 5'd1;
          bit_cnt_reg <= 4'd0;
        end
      end else begin
        if (pll_en && edge_seen && phase_reg != mid - 5'd1) begin
          phase_reg <= 5'd1; // [RULE_10]
        end else if (phase_reg == cell_len) begin
          phase_reg <= 5'd0;
        end else begin
          phase_reg <= phase_reg + 5'd1;
        end
        if (sample) begin
          nrzi_prev_reg <= rx_in;
          if (bit_cnt_reg == 4'd0) begin
            busy_reg <= ~rx_in;
            bit_cnt_reg <= rx_in ? 4'd0 : 4'd1;
          end else if (bit_cnt_reg == 4'd9) begin
            busy_reg <= 1'b0;
            bit_cnt_reg <= 4'd0;
          end else begin
            shift_reg <= {dec_bit, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end
        end
      end
    end
  end

  // =====================================================================
  // Receive FIFO with holding shift register; hunt never flushes it.
  wire stop_sample = sample && bit_cnt_reg == 4'd9;
  wire new_char = stop_sample; // [RULE_04]
  wire pop = rd_en && paddr == `SCRX_OFF_DATA && level_reg != 2'd0;
  wire push = pend_reg && (!fifo_full || pop);
  wire overrun = new_char && pend_reg && fifo_full && !pop; // [RULE_02]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_reg <= 2'd0;
      wr_ptr_reg <= 2'd0;
      level_reg <= 2'd0;
      pend_reg <= 1'b0;
      pend_data_reg <= 8'h00;
      last_reg <= 8'h00;
    end else if (srst) begin
      rd_ptr_reg <= 2'd0; // [RULE_05]
      wr_ptr_reg <= 2'd0;
      level_reg <= 2'd0;
      pend_reg <= 1'b0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= pend_data_reg;
        wr_ptr_reg <= (wr_ptr_reg == 2'd2) ? 2'd0 : wr_ptr_reg + 2'd1;
      end
      if (pop) begin
        last_reg <= fifo_mem[rd_ptr_reg]; // [RULE_03]
        rd_ptr_reg <= (rd_ptr_reg == 2'd2) ? 2'd0 : rd_ptr_reg + 2'd1;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 2'd1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 2'd1;
      end
      if (new_char) begin
        pend_reg <= 1'b1;
        pend_data_reg <= shift_reg;
      end else if (push) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Sticky status; set wins over write-one-to-clear.
  wire [3:0] ev;
  assign ev[`SCRX_ST_AVAIL] = push;
  assign ev[`SCRX_ST_OVERRUN] = overrun; // [RULE_18]
  assign ev[`SCRX_ST_FRAMING] = stop_sample && !rx_in;
  assign ev[`SCRX_ST_ZERO] = div_zero;
  wire [3:0] w1c = (wr_en && paddr == `SCRX_OFF_STATUS) ? pwdata[3:0] : 4'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 4'h0;
      mask_reg <= 4'h0;
      ctrl_reg <= `SCRX_CTRL_RESET;
      tc_reg <= `SCRX_DIV_RESET;
      irq <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~w1c) | ev; // [RULE_18]
      irq <= |(((status_reg & ~w1c) | ev) & mask_reg);
      if (wr_en && paddr == `SCRX_OFF_CTRL) begin
        ctrl_reg <= {1'b0, pwdata[6:0]};
      end
      if (wr_en && paddr == `SCRX_OFF_DIV) begin
        tc_reg <= pwdata[DIV_W-1:0];
      end
      if (wr_en && paddr == `SCRX_OFF_MASK) begin
        mask_reg <= pwdata[3:0];
      end
    end
  end

  // =====================================================================
  // APB read path, no wait states.
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `SCRX_OFF_CTRL: rdata_next = {24'h00_0000, ctrl_reg};
      `SCRX_OFF_DIV: rdata_next = {{(32-DIV_W){1'b0}}, tc_reg};
      `SCRX_OFF_STATUS: rdata_next = {28'h000_0000, status_reg};
      `SCRX_OFF_MASK: rdata_next = {28'h000_0000, mask_reg};
      `SCRX_OFF_DATA: rdata_next = {24'h00_0000, (level_reg != 2'd0) ? fifo_mem[rd_ptr_reg] : last_reg};
      `SCRX_OFF_LEVEL: rdata_next = {29'h0000_0000, pend_reg, level_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  wire mapped = paddr == `SCRX_OFF_CTRL || paddr == `SCRX_OFF_DIV || paddr == `SCRX_OFF_STATUS ||
                paddr == `SCRX_OFF_MASK || paddr == `SCRX_OFF_DATA || paddr == `SCRX_OFF_LEVEL;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= rdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ### tb/scrx_station.sv
`timescale 1ns/100ps
// ==========
// Remote station that drives the receive line.
module scrx_station (
  // Clock.
  input logic pclk,
  // Line.
  output logic rxd
);
  initial rxd = 1'b1;
  // Sends one 8N1 character, LSB first; noise corrupts the outer quarters of data cells.
  task automatic send(input logic [7:0] b, input int bt, input bit noise);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < bt; c++) begin
        @(posedge pclk);
        rxd <= (noise && i > 0 && i < 9 && (c < bt / 4 || c >= bt - bt / 4)) ^ f[i];
      end
    end
  endtask
endmodule

// ### tb/scrx_chk_sva.sv
`timescale 1ns/100ps
// ==========
// Port checker for the receive channel.
module scrx_chk #(
  parameter DIV_W = 16
) (
  // Clock, reset and bus.
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Serial pins and interrupt.
  input logic rxd,
  input logic tx_data,
  input logic txd,
  input logic irq
);
  logic echo_q;
  logic loop_q;
  logic mz;
  // Tracks echo, loopback and an all-zero mask from completed writes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_q <= 1'b0;
      loop_q <= 1'b0;
      mz <= 1'b1;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 12'h000) begin
        echo_q <= pwdata[2];
        loop_q <= pwdata[1];
      end
      if (paddr == 12'h00c) begin
        mz <= (pwdata[3:0] == 4'h0);
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_answer: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h014 |=> pslverr) else $error("no error");
  a_mapped_ok: assert property (psel && !penable && paddr[1:0] == 2'b00 && paddr <= 12'h014 |=> !pslverr)
    else $error("error on mapped address");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_echo_follows: assert property ((echo_q && $stable(rxd))[*4] |-> txd == rxd)
    else $error("echo path lost");
  a_tx_direct: assert property ((!echo_q && !loop_q && $stable(tx_data))[*4] |-> txd == tx_data)
    else $error("transmit path lost");
  a_irq_masked: assert property ((mz)[*3] |-> !irq) else $error("masked interrupt raised");
endmodule
bind scrx_channel scrx_chk #(.DIV_W(DIV_W)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .tx_data(tx_data), .txd(txd), .irq(irq));

// ### tb/serial_channel_rx_clocking_tb.sv
`timescale 1ns/100ps
`include "scrx_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
// ==========
// Self-checking bench for the receive channel.
module serial_channel_rx_clocking_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic tx_data = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, rxd, txd, irq, er;
  int num_errors = 0;
  int check_count = 0;
  int seed = 32'he29d2d41;
  logic [7:0] b [5];
  always #4 pclk = ~pclk;
  scrx_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .tx_data(tx_data), .txd(txd), .irq(irq));
  scrx_station station_u (.pclk(pclk), .rxd(rxd));
  always @(posedge pclk) if ($random(seed) % 8 == 0) tx_data <= 1'($random(seed));
  function int bit_cyc(int tc, bit pll);
    return (pll ? 32 : 16) * (tc + 1);
  endfunction
  function int pick(int k);
    return k < 3 ? k : 4;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      apb(0, 12'(a * 4), 0);
      `CHK(rd, (a == 2) ? 32'h0000_0008 : 32'h0000_0000)
    end
    apb(0, 12'h018, 0);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("test reset done");
    apb(1, `SCRX_OFF_DIV, 32'h0000_0003);
    apb(1, `SCRX_OFF_CTRL, 32'h0000_0081);
    b[0] = 8'($random(seed));
    station_u.send(b[0], bit_cyc(3, 0), 1);
    apb(0, `SCRX_OFF_DATA, 0);
    `CHK(rd[7:0], b[0])
    $display("test sampling done");
    apb(1, `SCRX_OFF_STATUS, 32'h0000_000f);
    apb(1, `SCRX_OFF_MASK, 32'h0000_0002);
    for (int k = 0; k < 5; k++) begin
      b[k] = 8'($random(seed));
      station_u.send(b[k], bit_cyc(3, 0), 0);
    end
    apb(0, `SCRX_OFF_STATUS, 0);
    `CHK(rd[1], 1'b1)
    `CHK(irq, 1'b1)
    apb(0, `SCRX_OFF_LEVEL, 0);
    `CHK(rd[1:0], 2'd3)
    apb(1, `SCRX_OFF_CTRL, 32'h0000_0041);
    for (int m = 0; m < 3; m++) begin
      apb(1, m == 2 ? `SCRX_OFF_STATUS : `SCRX_OFF_MASK, m == 0 ? 0 : 2);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'(m == 1))
    end
    for (int k = 0; k < 5; k++) begin
      apb(0, `SCRX_OFF_DATA, 0);
      `CHK(rd[7:0], b[pick(k)])
    end
    $display("test overrun done");
    apb(1, `SCRX_OFF_DIV, 32'h0000_0001);
    apb(1, `SCRX_OFF_CTRL, 32'h0000_0089);
    for (int k = 0; k < 3; k++) begin
      b[k] = 8'($random(seed));
      station_u.send(b[k], bit_cyc(1, 1) + (k - 1) * 2, 0);
      apb(0, `SCRX_OFF_DATA, 0);
      `CHK(rd[7:0], b[k])
    end
    apb(1, `SCRX_OFF_CTRL, 32'h0000_0099);
    b[3] = 8'($random(seed));
    station_u.send(b[3], bit_cyc(1, 0), 0);
    apb(0, `SCRX_OFF_DATA, 0);
    `CHK(rd[7:0], b[3])
    $display("test loop clock done");
    apb(1, `SCRX_OFF_CTRL, 32'h0000_0007);
    fork
      station_u.send(8'h00, 64, 0);
      begin
        repeat (300) @(posedge pclk);
        `CHK(txd, rxd)
      end
    join
    apb(1, `SCRX_OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    $display("test echo done");
    wrap_up;
  end
endmodule
